// ### design/sys_glue.sv
// Purpose: Clock enable, reset sequencing, memory decode, control words, interrupt glue
// Assumes: i_ref_clk is the instruction clock; enables mark input-clock phases
// Notes: Control words answer only while running; pins pass two flip-flops
// Notes on behaviour
// RULE1 - Sixteen sources: five core, eleven peripheral
// RULE2 - Peripheral sources merged onto one line
// RULE3 - Fixed priority, each source maskable
// RULE4 - Program RAM 512 words from zero
// RULE5 - Program ROM block at 0x0800
// RULE6 - Vector, RAM, reserved, ROM, reserved ranges
// RULE7 - Data RAM, peripherals, control, rest reserved
// RULE8 - Instruction rate twice input, clock out
// RULE9 - External input clock runs continuously
// RULE10 - Hold reset 2^16 cycles after supply
// RULE11 - Low reset pin gives full reset
// RULE12 - Reset empties stacks, masks, clears status
// RULE13 - Fetch starts at 0x0800 after reset
// RULE14 - Bit 10 selects serial port pins
// RULE15 - Software keeps other control bits zero
// RULE16 - Wait-state word at 0x3FFE, resets 0xFFFF
// RULE17 - Software writes 0x8000 to wait word
// RULE18 - Reserved accesses have no side effects
`timescale 1ns/1ps
`default_nettype none
module sys_glue #(
    parameter int POR_HOLD = sys_glue_pkg::POR_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_supply_ok,
    input wire logic i_reset_n,
    input wire logic [13:0] i_pm_addr,
    input wire logic [13:0] i_dm_addr,
    input wire logic i_dm_wr,
    input wire logic i_dm_rd,
    input wire logic [15:0] i_dm_wdata,
    input wire logic [4:0] i_core_irq,
    input wire logic [8:0] i_pio_irq,
    input wire logic i_pwm_sync_pulse,
    input wire logic i_pwm_trip_input,
    input wire logic [15:0] i_irq_mask,
    output logic o_instruction_clock_out,
    output logic o_half_rate_en,
    output logic o_sys_reset,
    output logic o_clear_stacks,
    output logic o_clear_mode_status_word,
    output logic [13:0] o_fetch_addr,
    output logic o_fetch_load,
    output logic [3:0] o_pm_sel,
    output logic [3:0] o_dm_sel,
    output logic [15:0] o_dm_rdata,
    output logic o_ctrl_rvalid,
    output logic o_serial_port_one_en,
    output logic [15:0] o_wait_state_control,
    output logic o_peripheral_interrupt_line,
    output logic o_irq_any,
    output logic [3:0] o_irq_idx
);
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] sup_sync;
        logic [1:0] trip_sync;
        sys_glue_pkg::rst_state_t st;
        logic [16:0] cnt;
        logic half;
        logic fetch;
        logic [15:0] wsc;
        logic [15:0] scw;
        logic [15:0] rdata;
        logic rvalid;
    } state_t;

    state_t s_q, s_d;
    sys_glue_pkg::pm_sel_t pm;
    sys_glue_pkg::dm_sel_t dm;
    logic [15:0] src;
    logic [15:0] eff_mask;
    logic in_reset;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic in_rng(input logic [13:0] a, input logic [13:0] lo, input logic [13:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // RULE4 - program RAM decode
    // RULE5 - program ROM decode
    // RULE6 - program range split
    always_comb begin
        pm.pm_vec = in_rng(i_pm_addr, sys_glue_pkg::PM_VEC_LO, sys_glue_pkg::PM_VEC_HI);
        pm.pm_ram = in_rng(i_pm_addr, sys_glue_pkg::PM_VEC_HI + 14'h0001, sys_glue_pkg::PM_RAM_HI);
        pm.pm_rom = in_rng(i_pm_addr, sys_glue_pkg::PM_ROM_LO, sys_glue_pkg::PM_ROM_HI);
        pm.pm_rsvd = !(pm.pm_vec || pm.pm_ram || pm.pm_rom);
    end

    // RULE7 - data space decode
    always_comb begin
        dm.dm_periph = in_rng(i_dm_addr, sys_glue_pkg::DM_PERIPH_LO, sys_glue_pkg::DM_PERIPH_HI);
        dm.dm_ram = in_rng(i_dm_addr, sys_glue_pkg::DM_RAM_LO, sys_glue_pkg::DM_RAM_HI);
        dm.dm_ctrl = (i_dm_addr >= sys_glue_pkg::DM_CTRL_LO);
        dm.dm_rsvd = !(dm.dm_periph || dm.dm_ram || dm.dm_ctrl);
    end

    ////////////////////////////////////////////////////////////////////////////
    // RULE1 - sixteen sources
    // RULE2 - peripheral line merge
    assign o_peripheral_interrupt_line = (|i_pio_irq) | i_pwm_sync_pulse | !s_q.trip_sync[1];
    // RULE12 - interrupts masked in reset
    assign eff_mask = in_reset ? 16'h0000 : i_irq_mask;
    // RULE1 - source vector order
    // Trip pin is active low, so its synchronised copy is inverted into a request
    assign src = {i_pio_irq, i_pwm_sync_pulse, !s_q.trip_sync[1], i_core_irq};

    // RULE3 - masked sources into priority
    irq_combine u_irq (
        .i_req(src),
        .i_mask(eff_mask),
        .o_any(o_irq_any),
        .o_idx(o_irq_idx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // RULE12 - not running means reset
    assign in_reset = (s_q.st != sys_glue_pkg::RST_RUN);

    always_comb begin
        s_d = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], i_reset_n};
        s_d.sup_sync = {s_q.sup_sync[0], i_supply_ok};
        s_d.trip_sync = {s_q.trip_sync[0], i_pwm_trip_input};
        // RULE8 - half-rate input phase
        s_d.half = !s_q.half;
        s_d.fetch = 1'b0;
        s_d.rvalid = 1'b0;
        case (s_q.st)
            sys_glue_pkg::RST_POWER: begin
                // RULE10 - count restarts while unpowered
                s_d.cnt = sys_glue_pkg::POR_CNT_RST;
                if (s_q.sup_sync[1]) begin
                    s_d.st = sys_glue_pkg::RST_HOLD;
                end
            end
            sys_glue_pkg::RST_HOLD: begin
                // RULE10 - extra hold count
                s_d.cnt = s_q.cnt + 17'h0_0001;
                if (s_q.cnt == 17'(POR_HOLD - 1)) begin
                    s_d.st = sys_glue_pkg::RST_RUN;
                    // RULE13 - fetch from ROM
                    s_d.fetch = 1'b1;
                end
            end
            sys_glue_pkg::RST_RUN: begin
                // RULE16 - wait word write
                if (i_dm_wr && i_dm_addr == sys_glue_pkg::WAIT_STATE_CONTROL_ADDR) begin
                    s_d.wsc = i_dm_wdata;
                end
                // RULE14 - serial select word
                if (i_dm_wr && i_dm_addr == sys_glue_pkg::SYSTEM_CONTROL_WORD_ADDR) begin
                    s_d.scw = i_dm_wdata;
                end
                // Only control space answers; other spaces belong to the memories
                if (i_dm_rd && dm.dm_ctrl) begin
                    s_d.rvalid = 1'b1;
                    // RULE18 - reserved reads zero
                    s_d.rdata = 16'h0000;
                    if (i_dm_addr == sys_glue_pkg::WAIT_STATE_CONTROL_ADDR) begin
                        s_d.rdata = s_q.wsc;
                    end
                    if (i_dm_addr == sys_glue_pkg::SYSTEM_CONTROL_WORD_ADDR) begin
                        s_d.rdata = s_q.scw;
                    end
                end
            end
            default: begin
                s_d.st = sys_glue_pkg::RST_POWER;
            end
        endcase
        // RULE11 - pin reset restarts
        if (!s_q.rst_sync[1] || !s_q.sup_sync[1]) begin
            s_d.st = sys_glue_pkg::RST_POWER;
            // RULE16 - wait word default
            s_d.wsc = sys_glue_pkg::WAIT_STATE_CONTROL_RST;
            s_d.scw = sys_glue_pkg::SYSTEM_CONTROL_WORD_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset pin can hold low for long; supply loss also restarts the hold count
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.st <= sys_glue_pkg::RST_POWER;
            s_q.wsc <= sys_glue_pkg::WAIT_STATE_CONTROL_RST;
            s_q.scw <= sys_glue_pkg::SYSTEM_CONTROL_WORD_RST;
            // Trip idles high so leaving reset raises no false request
            s_q.trip_sync <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from registered state or the decode
    // RULE8 - clock out and enable
    assign o_instruction_clock_out = s_q.half;
    assign o_half_rate_en = s_q.half;
    assign o_sys_reset = in_reset;
    // RULE12 - stacks and status cleared
    assign o_clear_stacks = in_reset;
    assign o_clear_mode_status_word = in_reset;
    // RULE13 - fixed restart address
    assign o_fetch_addr = sys_glue_pkg::RESET_FETCH_ADDR;
    assign o_fetch_load = s_q.fetch;
    // RULE6 - program decode flags
    assign o_pm_sel = pm;
    // RULE7 - data decode flags
    assign o_dm_sel = dm;
    assign o_dm_rdata = s_q.rdata;
    assign o_ctrl_rvalid = s_q.rvalid;
    // RULE14 - pin function select
    assign o_serial_port_one_en = s_q.scw[sys_glue_pkg::SERIAL_SEL_BIT];
    assign o_wait_state_control = s_q.wsc;
endmodule
`default_nettype wire

// ### design/sys_glue_pkg.sv
// Purpose: Shared constants and carriers for the system glue block
// Assumes: 14-bit program and data addresses, one instruction clock
// Notes: Offsets are word addresses on the core memory buses
package sys_glue_pkg;
    localparam logic [13:0] PM_VEC_LO = 14'h0000;
    localparam logic [13:0] PM_VEC_HI = 14'h002F;
    localparam logic [13:0] PM_RAM_HI = 14'h01FF;
    localparam logic [13:0] PM_ROM_LO = 14'h0800;
    localparam logic [13:0] PM_ROM_HI = 14'h17FF;
    localparam logic [13:0] DM_PERIPH_LO = 14'h2000;
    localparam logic [13:0] DM_PERIPH_HI = 14'h20FF;
    localparam logic [13:0] DM_RAM_LO = 14'h3800;
    localparam logic [13:0] DM_RAM_HI = 14'h39FF;
    localparam logic [13:0] DM_CTRL_LO = 14'h3C00;
    localparam logic [13:0] WAIT_STATE_CONTROL_ADDR = 14'h3FFE;
    localparam logic [13:0] SYSTEM_CONTROL_WORD_ADDR = 14'h3FFF;
    localparam logic [15:0] WAIT_STATE_CONTROL_RST = 16'hFFFF;
    localparam logic [15:0] SYSTEM_CONTROL_WORD_RST = 16'h0000;
    localparam int SERIAL_SEL_BIT = 10;
    localparam logic [13:0] RESET_FETCH_ADDR = 14'h0800;
    localparam int CLK_MHZ = 100;
    localparam int POR_CYCLES = 65536;
    localparam int NUM_PIO_IRQ = 9;
    localparam int NUM_SRC = 16;
    localparam logic [16:0] POR_CNT_RST = 17'h0_0000;

    typedef enum logic [2:0] {
        RST_POWER = 3'b001,
        RST_HOLD = 3'b010,
        RST_RUN = 3'b100
    } rst_state_t;

    typedef struct packed {
        logic pm_vec;
        logic pm_ram;
        logic pm_rom;
        logic pm_rsvd;
    } pm_sel_t;

    typedef struct packed {
        logic dm_periph;
        logic dm_ram;
        logic dm_ctrl;
        logic dm_rsvd;
    } dm_sel_t;
endpackage

// ### design/irq_combine.sv
// Purpose: Prioritised, individually masked interrupt selection
// Assumes: Sources are level requests on the instruction clock
// Notes: Lowest index wins
`timescale 1ns/1ps
`default_nettype none
module irq_combine (
    input wire logic [15:0] i_req,
    input wire logic [15:0] i_mask,
    output logic o_any,
    output logic [3:0] o_idx
);
    logic [15:0] live;
    // RULE3 - mask then priority
    always_comb begin
        live = i_req & i_mask;
        o_any = |live;
        o_idx = 4'h0;
        for (int k = sys_glue_pkg::NUM_SRC - 1; k >= 0; k--) begin
            if (live[k]) begin
                o_idx = 4'(k);
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/sys_glue_properties.sv
// Purpose: Port level checks for sys_glue
// Assumes: Bound from the bench top, all signals on the instruction clock
// Notes: Decode is checked every cycle against the address maps
`timescale 1ns/1ps
`default_nettype none
module sys_glue_properties #(
    parameter int POR_HOLD = sys_glue_pkg::POR_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reset_n,
    input wire logic i_supply_ok,
    input wire logic [13:0] i_pm_addr,
    input wire logic [13:0] i_dm_addr,
    input wire logic i_dm_wr,
    input wire logic [15:0] i_dm_wdata,
    input wire logic o_instruction_clock_out,
    input wire logic o_half_rate_en,
    input wire logic o_sys_reset,
    input wire logic o_clear_stacks,
    input wire logic o_clear_mode_status_word,
    input wire logic [13:0] o_fetch_addr,
    input wire logic o_fetch_load,
    input wire logic [3:0] o_pm_sel,
    input wire logic [3:0] o_dm_sel,
    input wire logic o_serial_port_one_en,
    input wire logic [15:0] o_wait_state_control,
    input wire logic o_irq_any
);
    logic [16:0] hold_q;
    wire run_wr = i_dm_wr && !o_sys_reset;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////
    // Counts reset cycles so the release can be judged late enough
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !o_sys_reset) begin
            hold_q <= 17'h0_0000;
        end else begin
            hold_q <= hold_q + 17'h0_0001;
        end
    end
    ////////////////////////////////////////////////////////////
    clk_rate_a: assert property (!$past(i_rst) |-> o_instruction_clock_out != $past(o_instruction_clock_out)
        && o_half_rate_en != $past(o_half_rate_en)) else $error("clock out stuck");
    pm_map_a: assert property (o_pm_sel == {i_pm_addr <= 14'h002F, i_pm_addr inside {[14'h0030:14'h01FF]},
        i_pm_addr inside {[14'h0800:14'h17FF]}, !(i_pm_addr inside {[14'h0000:14'h01FF], [14'h0800:14'h17FF]})})
        else $error("program decode wrong");
    dm_map_a: assert property (o_dm_sel == {i_dm_addr inside {[14'h2000:14'h20FF]},
        i_dm_addr inside {[14'h3800:14'h39FF]}, i_dm_addr >= 14'h3C00,
        !(i_dm_addr inside {[14'h2000:14'h20FF], [14'h3800:14'h39FF], [14'h3C00:14'h3FFF]})})
        else $error("data decode wrong");
    fetch_start_a: assert property ($fell(o_sys_reset) |-> hold_q >= POR_HOLD && o_fetch_load
        && o_fetch_addr == 14'h0800) else $error("early release or bad fetch");
    pin_reset_a: assert property (!i_reset_n [*4] |=> o_sys_reset) else $error("pin reset ignored");
    reset_outs_a: assert property (o_sys_reset |-> o_clear_stacks && o_clear_mode_status_word && !o_irq_any)
        else $error("reset effects missing");
    wait_write_a: assert property (run_wr && i_dm_addr == 14'h3FFE |=> o_wait_state_control == $past(i_dm_wdata))
        else $error("wait word not written");
    serial_sel_a: assert property (run_wr && i_dm_addr == 14'h3FFF
        |=> o_serial_port_one_en == $past(i_dm_wdata[10])) else $error("serial select wrong");
    rsvd_write_a: assert property (run_wr && i_reset_n && i_supply_ok && i_dm_addr < 14'h3FFE
        |=> $stable(o_wait_state_control) && $stable(o_serial_port_one_en)) else $error("stray write landed");
endmodule
`default_nettype wire

// ### dv/core_model.sv
// Purpose: Core side data bus master for the control words
// Assumes: One strobe cycle per access, answer one cycle later
// Notes: An idle bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic i_ref_clk,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic [13:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_wdata
);
    initial begin
        o_addr = 14'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 16'h0000;
    end
    task automatic cyc(input logic w, input logic [13:0] a, input logic [15:0] wd, output logic [15:0] d,
        output logic v);
        @(posedge i_ref_clk);
        #1;
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = wd;
        @(posedge i_ref_clk);
        #1;
        // Stale values would hide a decoder that latches late
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~wd;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule
`default_nettype wire

// ### dv/sys_glue_bench.sv
// Purpose: Directed bench for sys_glue
// Assumes: Short reset hold parameter, inputs moved 1 ns after the edge
// Notes: Decode and reset timing are also watched by the bound checker
`timescale 1ns/1ps
`default_nettype none
module sys_glue_bench;
    localparam int POR = 16;
    logic i_ref_clk, i_rst, i_supply_ok, i_reset_n, i_dm_wr, i_dm_rd, i_pwm_sync_pulse, i_pwm_trip_input;
    logic [13:0] i_pm_addr, i_dm_addr, o_fetch_addr;
    logic [15:0] i_dm_wdata, i_irq_mask, o_dm_rdata, o_wait_state_control, d;
    logic [4:0] i_core_irq;
    logic [8:0] i_pio_irq;
    logic [3:0] o_pm_sel, o_dm_sel, o_irq_idx;
    logic o_instruction_clock_out, o_half_rate_en, o_sys_reset, o_clear_stacks, o_clear_mode_status_word;
    logic o_fetch_load, o_ctrl_rvalid, o_serial_port_one_en, o_peripheral_interrupt_line, o_irq_any, v;
    int failures = 0;
    int cmp_count = 0;
    int n;
    logic [13:0] pm_pts [9] = '{14'h002F, 14'h0030, 14'h01FF, 14'h0200, 14'h07FF, 14'h0800, 14'h17FF, 14'h1800, 14'h3FFF};
    logic [13:0] dm_pts [9] = '{14'h1FFF, 14'h2000, 14'h20FF, 14'h2100, 14'h37FF, 14'h3800, 14'h39FF, 14'h3A00, 14'h3C00};
    sys_glue #(.POR_HOLD(POR)) uut (.*);
    core_model core (.i_ref_clk(i_ref_clk), .i_rvalid(o_ctrl_rvalid), .i_rdata(o_dm_rdata), .o_addr(i_dm_addr),
        .o_wr(i_dm_wr), .o_rd(i_dm_rd), .o_wdata(i_dm_wdata));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t saw %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_run(output int c);
        c = 0;
        while (o_sys_reset !== 1'b0 && c < 1000) begin
            @(posedge i_ref_clk);
            #1;
            c++;
        end
        if (c >= 1000) begin
            failures++;
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Input clock never stops during the run
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #100000;
        failures++;
        end_sim();
    end
    initial begin
        {i_rst, i_supply_ok, i_reset_n, i_pwm_trip_input} = 4'hF;
        {i_pm_addr, i_core_irq, i_pio_irq, i_pwm_sync_pulse, i_irq_mask} = '0;
        repeat (10) @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        wait_run(n);
        chk(17'(n >= POR), 17'(1'b1));
        chk(17'(o_wait_state_control), 17'(16'hFFFF));
        core.cyc(1'b1, 14'h3FFE, 16'h8000, d, v);
        core.cyc(1'b1, 14'h3FFF, 16'h0400, d, v);
        chk(17'(o_serial_port_one_en), 17'(1'b1));
        core.cyc(1'b0, 14'h3FFE, 16'h0000, d, v);
        chk({v, d}, {1'b1, 16'h8000});
        core.cyc(1'b1, 14'h3C00, 16'h1234, d, v);
        core.cyc(1'b0, 14'h3C00, 16'h0000, d, v);
        chk({v, d}, {1'b1, 16'h0000});
        core.cyc(1'b1, 14'h3FFF, 16'h0000, d, v);
        chk(17'(o_serial_port_one_en), 17'(1'b0));
        for (int i = 0; i < 9; i++) begin
            i_pm_addr = pm_pts[i];
            core.cyc(1'b1, dm_pts[i], 16'hFFFF, d, v);
        end
        chk(17'(o_wait_state_control), 17'(16'h8000));
        {i_core_irq, i_pio_irq, i_pwm_sync_pulse, i_pwm_trip_input} = {5'h1F, 9'h1FF, 2'h2};
        for (int i = 0; i < 16; i++) begin
            i_irq_mask = 16'hFFFF << i;
            repeat (3) @(posedge i_ref_clk);
            #1;
            chk(17'({o_irq_any, o_irq_idx}), 17'({1'b1, 4'(i)}));
        end
        i_core_irq = 5'h00;
        @(posedge i_ref_clk);
        #1;
        chk(17'(o_peripheral_interrupt_line), 17'(1'b1));
        {i_pio_irq, i_pwm_sync_pulse, i_pwm_trip_input} = {9'h000, 2'h1};
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk(17'({o_peripheral_interrupt_line, o_irq_any}), 17'(2'h0));
        i_reset_n = 1'b0;
        repeat (6) @(posedge i_ref_clk);
        #1;
        chk({o_sys_reset, o_wait_state_control}, {1'b1, 16'hFFFF});
        i_reset_n = 1'b1;
        wait_run(n);
        chk(17'(n >= POR), 17'(1'b1));
        chk({o_serial_port_one_en, o_wait_state_control}, {1'b0, 16'hFFFF});
        end_sim();
    end
endmodule
bind sys_glue sys_glue_properties #(.POR_HOLD(POR_HOLD)) props (.*);
`default_nettype wire
